// >>> hw/spss_pkg.sv
// Constants shared by the status pin source selection block
`default_nettype none
package spss_pkg;
  // Clock and timing figures, times in ns as given
  localparam int CLK_PERIOD_NS   = 25;
  localparam int ASSERT_STEP_NS  = 25900;
  localparam int RELEASE_STEP_NS = 6600000;
  localparam int RATE_PULSE_NS   = 200;
  localparam int ASSERT_STEP_CYCLES  = ASSERT_STEP_NS / CLK_PERIOD_NS;
  localparam int RELEASE_STEP_CYCLES = RELEASE_STEP_NS / CLK_PERIOD_NS;
  localparam int RATE_PULSE_CYCLES   = (RATE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] LOSS_STATUS_IDX = 8'h06;
  localparam logic [7:0] LOSS_FILTER_IDX = 8'h07;
  localparam logic [7:0] PIN_CONFIG_IDX  = 8'h09;
  localparam logic [7:0] REVISION_IDX    = 8'h0a;

  // Field positions
  localparam int RATE_MASK_LSB     = 6;
  localparam int RATE_MASK_W       = 5;
  localparam int SRC_SEL_LSB       = 3;
  localparam int FILTER_SEL_LSB    = 0;
  localparam int CONFIG_USED_W     = 11;
  localparam int ASSERT_DELAY_LSB  = 8;
  localparam int RELEASE_DELAY_LSB = 0;
  localparam int STATUS_LOSS_BIT   = 0;
  localparam int STATUS_RATE_LSB   = 1;

  // Reset values
  localparam logic [10:0] PIN_CONFIG_RESET    = 11'h000;
  localparam logic [7:0]  ASSERT_DELAY_RESET  = 8'h02;
  localparam logic [7:0]  RELEASE_DELAY_RESET = 8'h01;
  localparam logic [2:0]  RATE_RESET          = 3'h1;

  // Detected rate codes and carrier rate filter codes
  localparam logic [2:0] RATE_BELOW_MADI = 3'h0;
  localparam logic [2:0] RATE_HD         = 3'h3;
  localparam logic [2:0] RATE_3G         = 3'h4;
  localparam logic [2:0] FILTER_ANY      = 3'h0;
  localparam logic [2:0] FILTER_LAST     = 3'h5;

  typedef enum logic [2:0] {
    SRC_LOSS       = 3'h0,
    SRC_CARRIER    = 3'h1,
    SRC_RSVD2      = 3'h2,
    SRC_RATE_PULSE = 3'h3,
    SRC_MASKED     = 3'h4,
    SRC_MASKED_GAP = 3'h5,
    SRC_RSVD6      = 3'h6,
    SRC_RSVD7      = 3'h7
  } spss_src_e;
endpackage
`default_nettype wire

// >>> hw/spss_loss_filter.sv
// Signal-loss filter with stepped assertion and release delays
`default_nettype none
module spss_loss_filter #(
  parameter int ASSERT_STEP  = spss_pkg::ASSERT_STEP_CYCLES,
  parameter int RELEASE_STEP = spss_pkg::RELEASE_STEP_CYCLES,
  parameter int CNT_W        = 20
) (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       ce,
  input  wire logic       lossRaw,
  input  wire logic [7:0] assertDelay,
  input  wire logic [7:0] releaseDelay,
  output logic            lossFiltered
);
  logic [CNT_W-1:0] preCnt_reg;
  logic [7:0]       stepCnt_reg;
  logic             filt_reg;

  wire             differs  = lossRaw != filt_reg;
  wire [7:0]       target   = lossRaw ? assertDelay : releaseDelay;
  wire [CNT_W-1:0] stepLast = lossRaw ? CNT_W'(ASSERT_STEP - 1) : CNT_W'(RELEASE_STEP - 1);
  wire             stepDone = preCnt_reg == stepLast;
  // Compared as at-least so a delay lowered mid-count still ends the wait
  wire             expired  = stepCnt_reg >= target;

  // Any bounce of the raw level restarts the whole delay
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      preCnt_reg  <= '0;
      stepCnt_reg <= 8'h00;
      filt_reg    <= 1'b0;
    end
    else if (ce)
    begin
      if (!differs || expired)
      begin
        preCnt_reg  <= '0;
        stepCnt_reg <= 8'h00;
        filt_reg    <= lossRaw;
      end
      else if (stepDone)
      begin
        preCnt_reg  <= '0;
        stepCnt_reg <= stepCnt_reg + 8'h01;
      end
      else
        preCnt_reg <= preCnt_reg + CNT_W'(1);
    end

  assign lossFiltered = filt_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  zero_delay_a: assert property (ce && lossRaw && !filt_reg && assertDelay == 8'h00 |=> filt_reg)
    else $error("Loss not asserted at once with zero delay");
  hold_assert_a: assert property (ce && lossRaw && !filt_reg && stepCnt_reg < assertDelay |=> !filt_reg)
    else $error("Loss asserted before its delay");
  hold_release_a: assert property (ce && !lossRaw && filt_reg && stepCnt_reg < releaseDelay |=> filt_reg)
    else $error("Loss released before its delay");
endmodule
`default_nettype wire

// >>> hw/spss_top.sv
// Status pin source selection with Wishbone register access
// How it works
// - A five-bit rate mask picks which detected rates are reported on the status pin in source codes 100 and 101.
// - Mask bit 0 is below-MADI, bit 1 MADI, bit 2 SD, bit 3 HD and bit 4 3G.
// - A three-bit source select picks the status pin source; codes 010, 110 and 111 are reserved and drive low.
// - Source code 001 shows carrier presence as narrowed by the carrier rate filter field.
// - Source code 011 gives a high pulse of at least 200 ns on each detected rate change.
// - Source code 100 shows carrier presence only while the detected rate is enabled in the mask.
// - Source code 101 is code 100 with a low gap of at least 200 ns on each rate change.
// - A three-bit carrier rate filter limits carrier reporting in source code 001 to one rate, code 000 meaning any rate.
// - Filter codes 001 to 101 select below-MADI, MADI, SD, HD and 3G; 110 and 111 are reserved.
// - A read-only 16-bit register returns the revision word and ignores writes.
// - Loss assertion is delayed by a programmable count of about 25.9 us steps.
// - Loss release is delayed by a programmable count of about 6.6 ms steps.
//
// The implementer's own choice: the Wishbone slave port.
`default_nettype none
module spss_top #(
  parameter logic [15:0] REVISION_WORD = 16'h5a01, // Arbitrary value
  parameter int          ASSERT_STEP   = spss_pkg::ASSERT_STEP_CYCLES,
  parameter int          RELEASE_STEP  = spss_pkg::RELEASE_STEP_CYCLES,
  parameter int          PULSE_CYCLES  = spss_pkg::RATE_PULSE_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic        ce,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        carrierRaw,
  input  wire logic [2:0]  detectedRate,
  output logic             statusPin
);
  localparam logic [7:0] STATUS_ADDR   = spss_pkg::LOSS_STATUS_IDX << 2;
  localparam logic [7:0] FILTER_ADDR   = spss_pkg::LOSS_FILTER_IDX << 2;
  localparam logic [7:0] CONFIG_ADDR   = spss_pkg::PIN_CONFIG_IDX << 2;
  localparam logic [7:0] REVISION_ADDR = spss_pkg::REVISION_IDX << 2;
  localparam logic [3:0] PULSE_LOAD    = 4'(PULSE_CYCLES);

  logic        ack_reg;
  logic [31:0] rdData_reg;
  logic [10:0] config_reg;
  logic [7:0]  assertDelay_reg;
  logic [7:0]  releaseDelay_reg;
  logic        carrierMeta_reg;
  logic        carrierSync_reg;
  logic [2:0]  prevRate_reg;
  logic [3:0]  pulseCnt_reg;
  logic        statusPin_reg;
  logic        lossFiltered;

  // Bus decode
  wire access     = wb_cyc_i && wb_stb_i && !ack_reg && ce;
  wire writeOp    = access && wb_we_i;
  wire hitStatus  = wb_adr_i == STATUS_ADDR;
  wire hitFilter  = wb_adr_i == FILTER_ADDR;
  wire hitConfig  = wb_adr_i == CONFIG_ADDR;
  wire hitVersion = wb_adr_i == REVISION_ADDR;
  wire cfgWrLo    = writeOp && hitConfig && wb_sel_i[0];
  wire cfgWrHi    = writeOp && hitConfig && wb_sel_i[1];
  wire filtWrLo   = writeOp && hitFilter && wb_sel_i[0];
  wire filtWrHi   = writeOp && hitFilter && wb_sel_i[1];

  // Configuration fields
  wire [4:0] rateMask  = config_reg[spss_pkg::RATE_MASK_LSB +: spss_pkg::RATE_MASK_W];
  wire [2:0] srcSelRaw = config_reg[spss_pkg::SRC_SEL_LSB +: 3];
  wire [2:0] filterSel = config_reg[spss_pkg::FILTER_SEL_LSB +: 3];
  spss_pkg::spss_src_e srcSel;
  assign srcSel = spss_pkg::spss_src_e'(srcSelRaw);

  // Unused upper bits read as zero, so the host sees what it must keep there
  wire [31:0] cfgRead    = {21'h0, config_reg};
  wire [31:0] filtRead   = {16'h0, assertDelay_reg, releaseDelay_reg};
  wire [31:0] statusRead = {28'h0, detectedRate, lossFiltered};
  wire [31:0] verRead    = {16'h0, REVISION_WORD};
  wire [31:0] readData   = hitConfig  ? cfgRead    :
                           hitFilter  ? filtRead   :
                           hitStatus  ? statusRead :
                           hitVersion ? verRead    : 32'h0;

  // Status pin sources
  wire       rateValid  = detectedRate <= spss_pkg::RATE_3G;
  wire [7:0] maskWide   = {3'h0, rateMask};
  wire       maskHit    = rateValid && maskWide[detectedRate];
  wire       filterOk   = filterSel <= spss_pkg::FILTER_LAST;
  wire       filterHit  = (filterSel == spss_pkg::FILTER_ANY) ||
                          (filterOk && detectedRate == filterSel - 3'h1);
  wire       carrierQual = carrierSync_reg && filterHit;
  wire       carrierMask = carrierSync_reg && maskHit;
  wire       rateChange  = detectedRate != prevRate_reg;
  wire       pulseActive = pulseCnt_reg != 4'h0;
  wire       pulseTerm   = rateChange || pulseActive;
  wire       statusNext  =
    (srcSel == spss_pkg::SRC_LOSS)       ? lossFiltered :
    (srcSel == spss_pkg::SRC_CARRIER)    ? carrierQual :
    (srcSel == spss_pkg::SRC_RATE_PULSE) ? pulseTerm :
    (srcSel == spss_pkg::SRC_MASKED)     ? carrierMask :
    (srcSel == spss_pkg::SRC_MASKED_GAP) ? carrierMask && !pulseTerm :
    1'b0;

  // Bus slave: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      ack_reg    <= 1'b0;
      rdData_reg <= 32'h0;
    end
    else if (ce)
    begin
      ack_reg <= access;
      if (access && !wb_we_i)
        rdData_reg <= readData;
    end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      config_reg <= spss_pkg::PIN_CONFIG_RESET;
    else
    begin
      if (cfgWrLo)
        config_reg[7:0] <= wb_dat_i[7:0];
      if (cfgWrHi)
        config_reg[10:8] <= wb_dat_i[10:8];
    end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      assertDelay_reg  <= spss_pkg::ASSERT_DELAY_RESET;
      releaseDelay_reg <= spss_pkg::RELEASE_DELAY_RESET;
    end
    else
    begin
      if (filtWrLo)
        releaseDelay_reg <= wb_dat_i[7:0];
      if (filtWrHi)
        assertDelay_reg <= wb_dat_i[15:8];
    end

  // Carrier level comes from the analog front end, so it is synchronised
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      carrierMeta_reg <= 1'b0;
      carrierSync_reg <= 1'b0;
    end
    else if (ce)
    begin
      carrierMeta_reg <= carrierRaw;
      carrierSync_reg <= carrierMeta_reg;
    end

  // A change during a running pulse restarts it, so pulses never merge short
  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
    begin
      prevRate_reg <= spss_pkg::RATE_RESET;
      pulseCnt_reg <= 4'h0;
    end
    else if (ce)
    begin
      prevRate_reg <= detectedRate;
      if (rateChange)
        pulseCnt_reg <= PULSE_LOAD;
      else if (pulseActive)
        pulseCnt_reg <= pulseCnt_reg - 4'h1;
    end

  always_ff @(posedge mclk or negedge reset_n)
    if (!reset_n)
      statusPin_reg <= 1'b0;
    else if (ce)
      statusPin_reg <= statusNext;

  spss_loss_filter #(
    .ASSERT_STEP  (ASSERT_STEP),
    .RELEASE_STEP (RELEASE_STEP),
    .CNT_W        (20)
  ) lossFilter (
    .mclk         (mclk),
    .reset_n      (reset_n),
    .ce           (ce),
    .lossRaw      (!carrierSync_reg),
    .assertDelay  (assertDelay_reg),
    .releaseDelay (releaseDelay_reg),
    .lossFiltered (lossFiltered)
  );

  assign wb_ack_o  = ack_reg;
  assign wb_dat_o  = rdData_reg;
  assign statusPin = statusPin_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  loss_mode_a: assert property ($past(ce) && $past(srcSelRaw) == 3'h0 |-> statusPin == $past(lossFiltered))
    else $error("Status pin does not follow filtered loss");
  carrier_any_a: assert property (ce && srcSelRaw == 3'h1 && filterSel == 3'h0 |=> statusPin == $past(carrierSync_reg))
    else $error("Status pin does not follow carrier presence");
  rate_filter_a: assert property (ce && srcSelRaw == 3'h1 && filterSel != 3'h0 && detectedRate != filterSel - 3'h1
                                  |=> !statusPin)
    else $error("Carrier reported for an unselected rate");
  reserved_src_a: assert property (ce && (srcSelRaw == 3'h2 || srcSelRaw >= 3'h6) |=> !statusPin)
    else $error("Reserved source code drives the pin");
  pulse_width_a: assert property (ce && rateChange |=> pulseActive [*8])
    else $error("Rate change pulse shorter than 200 ns");
  pulse_pin_a: assert property (ce && srcSelRaw == 3'h3 && rateChange |=> statusPin)
    else $error("Rate change pulse missing on pin");
  masked_hd_a: assert property (ce && srcSelRaw == 3'h4 && detectedRate == spss_pkg::RATE_HD && carrierSync_reg
                                |=> statusPin == $past(rateMask[3]))
    else $error("Masked carrier ignores the HD mask bit");
  mask_low_a: assert property (ce && srcSelRaw[2:1] == 2'b10 && detectedRate == spss_pkg::RATE_BELOW_MADI
                               && !rateMask[0] |=> !statusPin)
    else $error("Disabled rate reported on pin");
  gap_low_a: assert property (ce && srcSelRaw == 3'h5 && rateChange |=> !statusPin)
    else $error("No low gap on rate change");
  version_read_a: assert property (access && !wb_we_i && hitVersion
                                   |=> wb_ack_o && wb_dat_o[15:0] == REVISION_WORD)
    else $error("Revision word read wrong");

  cover_pulse_c: cover property (srcSelRaw == 3'h3 && statusPin [*8]);
  cover_gap_c: cover property (srcSelRaw == 3'h5 && statusPin ##1 !statusPin);
  cover_loss_c: cover property (srcSelRaw == 3'h0 && !statusPin ##1 statusPin);
  cover_write_c: cover property (cfgWrLo ##1 wb_ack_o);
endmodule
`default_nettype wire

// >>> sim/spss_host_monitor.sv
// Host-side monitor that measures how long the status pin stays at each level
`default_nettype none
module spss_host_monitor (
  input  wire logic       mclk,
  input  wire logic       reset_n,
  input  wire logic       statusPin,
  output logic      [7:0] highRun,
  output logic      [7:0] lowRun
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       lastPin;
  logic [7:0] runLen;
  // Saturate so a stuck pin never wraps round into a plausible pulse width
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      lastPin <= 1'b0;
      runLen  <= 8'h01;
      highRun <= 8'h00;
      lowRun  <= 8'h00;
    end
    else
    begin
      lastPin <= statusPin;
      if (statusPin != lastPin)
      begin
        runLen <= 8'h01;
        if (lastPin)
          highRun <= runLen;
        else
          lowRun <= runLen;
      end
      else if (runLen != 8'hff)
        runLen <= runLen + 8'h01;
    end
  end
endmodule
`default_nettype wire

// >>> sim/tb_status_pin_source_select.sv
// Self-checking bench for the status pin source selection block
`default_nettype none
module tb_status_pin_source_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0]  CFG_ADR  = 8'h24;
  localparam logic [7:0]  REV_ADR  = 8'h28;
  localparam logic [7:0]  FLT_ADR  = 8'h1c;
  localparam logic [7:0]  STS_ADR  = 8'h18;
  localparam logic [15:0] REV_WORD = 16'h3c5a; // Arbitrary value
  localparam int          PULSE    = 8;
  logic        mclk, resetN, ce, wbCyc, wbStb, wbWe, wbAck, carrierRaw, statusPin;
  logic [7:0]  wbAdr, highRun, lowRun;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, rd;
  logic [2:0]  detectedRate;
  logic [4:0]  mask;
  logic [2:0]  rsvd [3] = '{3'h2, 3'h6, 3'h7};
  int          n_errors, comparisons, seed, r;

  spss_top #(.REVISION_WORD(REV_WORD), .ASSERT_STEP(4), .RELEASE_STEP(8), .PULSE_CYCLES(PULSE)) spss_top_i (
    .mclk(mclk), .reset_n(resetN), .ce(ce), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .carrierRaw(carrierRaw), .detectedRate(detectedRate), .statusPin(statusPin));
  spss_host_monitor spss_host_monitor_i (
    .mclk(mclk), .reset_n(resetN), .statusPin(statusPin), .highRun(highRun), .lowRun(lowRun));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic end_of_test;
    $display("Errors: %0d, comparisons: %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic fail(input string msg);
    n_errors++;
    $display("mismatch at %0t: %s", $time, msg);
  endtask

  task automatic chkWord(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
      fail($sformatf("read %h, expected %h", got, exp));
  endtask

  task automatic chkPin(input logic exp);
    comparisons++;
    if (statusPin !== exp)
      fail($sformatf("status pin %b, expected %b", statusPin, exp));
  endtask

  task automatic chkWidth(input logic [7:0] got);
    comparisons++;
    if ((got >= 8'd8) !== 1'b1 || (got <= 8'd16) !== 1'b1)
      fail($sformatf("pulse of %0d cycles", got));
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Request held until ack is seen at a rising edge, then released
  task automatic wbXfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] data);
    int n;
    n = 0;
    @(posedge mclk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= adr;
    wbDatI <= wd;
    @(posedge mclk);
    while (wbAck !== 1'b1 && n < 100)
    begin
      @(posedge mclk);
      n++;
    end
    data = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe  <= 1'b0;
    if (n >= 100)
      fail("no bus ack");
  endtask

  task automatic cfgWrite(input logic [10:0] v);
    wbXfer(1'b1, CFG_ADR, {21'h000000, v}, rd);
  endtask

  task automatic setIn(input logic car, input logic [2:0] rt);
    @(posedge mclk);
    carrierRaw   <= car;
    detectedRate <= rt;
    waitCyc(6);
  endtask

  function automatic logic expCarrier(input logic [2:0] f, input logic [2:0] rt, input logic car);
    return car && (f == 3'h0 || (f <= 3'h5 && rt == f - 3'h1));
  endfunction

  function automatic logic expMasked(input logic [4:0] m, input logic [2:0] rt, input logic car);
    return car && rt <= 3'h4 && m[rt];
  endfunction

  initial
  begin
    repeat (20000) @(posedge mclk);
    fail("watchdog expired");
    end_of_test;
  end

  initial
  begin
    seed = 32'hcd672707;
    n_errors = 0;
    comparisons = 0;
    resetN = 1'b0;
    ce = 1'b1;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 8'h00;
    wbSel = 4'h3;
    wbDatI = 32'h00000000;
    carrierRaw = 1'b1;
    detectedRate = 3'h1;
    repeat (8) @(posedge mclk);
    resetN <= 1'b1;
    waitCyc(12);
    wbXfer(1'b0, CFG_ADR, 32'h0, rd);
    chkWord(rd, 32'h0);
    wbXfer(1'b1, REV_ADR, $random(seed), rd);
    wbXfer(1'b0, REV_ADR, 32'h0, rd);
    chkWord(rd, {16'h0000, REV_WORD});
    wbXfer(1'b0, 8'h3c, 32'h0, rd);
    chkWord(rd, 32'h0);
    // Carrier present at rate 1, loss clear
    wbXfer(1'b0, STS_ADR, 32'h0, rd);
    chkWord(rd, 32'h00000002);
    wbXfer(1'b0, FLT_ADR, 32'h0, rd);
    chkWord(rd, {16'h0000, spss_pkg::ASSERT_DELAY_RESET, spss_pkg::RELEASE_DELAY_RESET});
    // Loss path with the reset filter delays
    chkPin(1'b0);
    setIn(1'b0, 3'h1);
    chkPin(1'b0);
    waitCyc(30);
    chkPin(1'b1);
    setIn(1'b1, 3'h1);
    chkPin(1'b1);
    waitCyc(30);
    chkPin(1'b0);
    // Zero delays: loss follows the synchronised carrier within a few cycles
    wbXfer(1'b1, FLT_ADR, 32'h0, rd);
    wbXfer(1'b0, FLT_ADR, 32'h0, rd);
    chkWord(rd, 32'h0);
    setIn(1'b0, 3'h1);
    chkPin(1'b1);
    setIn(1'b1, 3'h1);
    chkPin(1'b0);
    for (int f = 0; f < 8; f++)
    begin
      cfgWrite({5'h00, 3'h1, f[2:0]});
      repeat (4)
      begin
        r = $random(seed);
        setIn(r[3], r[2:0]);
        chkPin(expCarrier(f[2:0], r[2:0], r[3]));
      end
    end
    for (int i = 0; i < 20; i++)
    begin
      r = $random(seed);
      mask = (i < 5) ? 5'h01 << i : r[8:4];
      cfgWrite({mask, 3'h4, 3'h0});
      wbXfer(1'b0, CFG_ADR, 32'h0, rd);
      chkWord(rd, {21'h000000, mask, 3'h4, 3'h0});
      setIn((i < 5) ? 1'b1 : r[3], (i < 5) ? i[2:0] : r[2:0]);
      chkPin(expMasked(mask, detectedRate, carrierRaw));
    end
    foreach (rsvd[k])
    begin
      cfgWrite({5'h1f, rsvd[k], 3'h0});
      setIn(1'b1, 3'h2);
      chkPin(1'b0);
    end
    cfgWrite({5'h00, 3'h3, 3'h0});
    waitCyc(30);
    chkPin(1'b0);
    setIn(1'b1, 3'h4);
    waitCyc(30);
    chkWidth(highRun);
    cfgWrite({5'h1f, 3'h5, 3'h0});
    waitCyc(30);
    chkPin(1'b1);
    setIn(1'b1, 3'h1);
    waitCyc(30);
    chkWidth(lowRun);
    chkPin(1'b1);
    // Clock enable low freezes the pin even though the carrier drops
    @(posedge mclk);
    ce <= 1'b0;
    setIn(1'b0, 3'h1);
    chkPin(1'b1);
    ce <= 1'b1;
    waitCyc(6);
    chkPin(1'b0);
    end_of_test;
  end
endmodule
`default_nettype wire
